// >>> design/fpx_frame.sv
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fpx_frame_regs.svh"
module fpx_frame
    import fpx_frame_pkg::*;
(
    input  wire logic           sys_clk_i,
    input  wire logic           reset_n_i,
    input  wire logic           exc_valid_i,
    input  wire fpx_report_type exc_report_i,
    input  wire logic           psel_i,
    input  wire logic           penable_i,
    input  wire logic           pwrite_i,
    input  wire logic [11:0]    paddr_i,
    input  wire logic [31:0]    pwdata_i,
    input  wire logic [3:0]     pstrb_i,
    output logic [31:0]         prdata_o,
    output logic                pready_o,
    output logic                pslverr_o,
    output logic                irq_o
);

////////////////////////////////////////////////////////////////////////////////
// Frame storage.

logic [15:0]             primary_command_word_r;
logic [15:0]             third_stage_command_word_r;
fpx_ext_type             source_temp_r;
fpx_ext_type             destination_temp_r;
fpx_wb_type              writeback_temp_r;
logic [2:0]              source_tag_r;
logic [2:0]              destination_tag_r;
logic                    primary_exception_flag_r;
logic                    third_stage_exception_flag_r;
logic                    post_instruction_flag_r;
logic [`FPX_NUM_EVT-1:0] status_r;
logic [`FPX_NUM_EVT-1:0] mask_r;
logic [`FPX_NUM_EVT-1:0] evt_set;
logic                    is_out;
logic                    take;
fpx_ext_type             signal_src;
logic                    apb_wr;
logic                    apb_rd;
logic [31:0]             rd_nxt;
logic                    err_nxt;

// A move-out is recognised from the opclass field of the command word.
assign is_out = (exc_report_i.cmd_word[`FPX_OPC_MSB:`FPX_OPC_LSB] == `FPX_OPC_OUT);
assign take   = exc_valid_i && (exc_report_i.exc != FPX_EXC_NONE);

// On a signalling-NaN move-out, the saved source carries its signalling bit set, as the handler expects.
always_comb begin
    signal_src = exc_report_i.src;
    signal_src.mantissa[`FPX_SIG_BIT] = 1'b1;
end

////////////////////////////////////////////////////////////////////////////////
// Frame loading. Fields not named for a case hold their old value, which
// saves enables and switching on the wide operand registers.

always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
        primary_command_word_r       <= 16'h0000;
        third_stage_command_word_r   <= 16'h0000;
        source_temp_r                <= '0;
        destination_temp_r           <= '0;
        writeback_temp_r             <= '0;
        source_tag_r                 <= `FPX_TAG_NORM;
        destination_tag_r            <= `FPX_TAG_NORM;
        primary_exception_flag_r     <= 1'b0;
        third_stage_exception_flag_r <= 1'b0;
        post_instruction_flag_r      <= 1'b0;
    end else if (take) begin
        // A new report restarts the flags; only the case below sets them.
        primary_exception_flag_r     <= 1'b0;
        third_stage_exception_flag_r <= 1'b0;
        post_instruction_flag_r      <= 1'b0;
        unique case (exc_report_i.exc)
            FPX_EXC_SIG_NAN: begin
                if (is_out) begin
                    primary_command_word_r   <= exc_report_i.cmd_word;
                    source_temp_r            <= signal_src;
                    source_tag_r             <= `FPX_TAG_NAN;
                    primary_exception_flag_r <= 1'b1;
                    post_instruction_flag_r  <= 1'b1;
                end else begin
                    primary_command_word_r   <= exc_report_i.cmd_word;
                    source_temp_r            <= exc_report_i.src;
                    source_tag_r             <= exc_report_i.src_tag;
                    if (exc_report_i.dst_valid) begin
                        destination_temp_r   <= exc_report_i.dst;
                        destination_tag_r    <= exc_report_i.dst_tag;
                    end
                    primary_exception_flag_r <= 1'b1;
                end
            end
            FPX_EXC_OPER: begin
                primary_command_word_r   <= exc_report_i.cmd_word;
                source_temp_r            <= exc_report_i.src;
                source_tag_r             <= exc_report_i.src_tag;
                primary_exception_flag_r <= 1'b1;
                if (is_out) begin
                    // Rounded integer lets the handler catch a false overflow.
                    writeback_temp_r.mantissa <= {3'h0, exc_report_i.rounded_int};
                    post_instruction_flag_r   <= 1'b1;
                end else if (exc_report_i.dst_valid) begin
                    destination_temp_r <= exc_report_i.dst;
                    destination_tag_r  <= exc_report_i.dst_tag;
                end
            end
            FPX_EXC_OVER: begin
                unique case (exc_report_i.grp)
                    FPX_GRP_DYADIC: begin
                        third_stage_command_word_r         <= exc_report_i.enc_cmd_word;
                        writeback_temp_r.sign              <= exc_report_i.res_rounded.sign;
                        writeback_temp_r.exponent          <= {1'b0, exc_report_i.res_rounded.exponent};
                        writeback_temp_r.mantissa[65:2]    <= exc_report_i.res_rounded.mantissa;
                        third_stage_exception_flag_r       <= 1'b1;
                    end
                    FPX_GRP_MOVE_REG,
                    FPX_GRP_MOVE_MEM: begin
                        primary_command_word_r   <= exc_report_i.cmd_word;
                        destination_temp_r       <= exc_report_i.res_rounded;
                        source_tag_r             <= `FPX_TAG_NORM;
                        primary_exception_flag_r <= 1'b1;
                        post_instruction_flag_r  <= (exc_report_i.grp == FPX_GRP_MOVE_MEM);
                    end
                    default: begin
                        primary_exception_flag_r <= 1'b1;
                    end
                endcase
            end
            FPX_EXC_UNDER: begin
                unique case (exc_report_i.grp)
                    FPX_GRP_DYADIC: begin
                        third_stage_command_word_r   <= exc_report_i.enc_cmd_word;
                        writeback_temp_r.sign        <= exc_report_i.wb_image.sign;
                        writeback_temp_r.exponent    <= {1'b1, exc_report_i.wb_image.exponent[14:0]};
                        // Bits 1..0 of the mantissa and the sticky are guard, round, sticky.
                        writeback_temp_r.mantissa    <= exc_report_i.wb_image.mantissa;
                        writeback_temp_r.sticky      <= exc_report_i.wb_image.sticky;
                        third_stage_exception_flag_r <= 1'b1;
                    end
                    FPX_GRP_MOVE_REG,
                    FPX_GRP_MOVE_MEM: begin
                        primary_command_word_r   <= exc_report_i.cmd_word;
                        destination_temp_r       <= exc_report_i.res_unrounded;
                        source_tag_r             <= `FPX_TAG_NORM;
                        primary_exception_flag_r <= 1'b1;
                        post_instruction_flag_r  <= (exc_report_i.grp == FPX_GRP_MOVE_MEM);
                    end
                    default: begin
                        primary_exception_flag_r <= 1'b1;
                    end
                endcase
            end
            FPX_EXC_DIV0: begin
                source_temp_r            <= exc_report_i.src;
                destination_temp_r       <= exc_report_i.dst;
                source_tag_r             <= exc_report_i.src_tag;
                primary_exception_flag_r <= 1'b1;
            end
            default: begin
                primary_exception_flag_r <= 1'b0;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt status: one sticky bit per exception class, write one to clear.

always_comb begin
    evt_set = '0;
    if (take && (exc_report_i.exc != FPX_EXC_NONE) && (exc_report_i.exc <= FPX_EXC_DIV0)) begin
        evt_set[exc_report_i.exc - 3'h1] = 1'b1;
    end
end

assign apb_wr = psel_i && penable_i && pwrite_i;
assign apb_rd = psel_i && !penable_i && !pwrite_i;

// The set term wins so an event in the clearing cycle is never lost.
always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
        status_r <= '0;
    end else if (apb_wr && (paddr_i == `FPX_OFF_STATUS) && pstrb_i[0]) begin
        status_r <= (status_r & ~pwdata_i[`FPX_NUM_EVT-1:0]) | evt_set;
    end else begin
        status_r <= status_r | evt_set;
    end
end

always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
        mask_r <= '0;
    end else if (apb_wr && (paddr_i == `FPX_OFF_MASK) && pstrb_i[0]) begin
        mask_r <= pwdata_i[`FPX_NUM_EVT-1:0];
    end
end

always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
        irq_o <= 1'b0;
    end else begin
        irq_o <= |((status_r | evt_set) & mask_r);
    end
end

////////////////////////////////////////////////////////////////////////////////
// APB read mux. Read data is registered in the setup cycle so the access
// phase completes in one cycle with pready already high.

always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    unique case (paddr_i)
        `FPX_OFF_STATUS: rd_nxt = {27'h0, status_r};
        `FPX_OFF_MASK:   rd_nxt = {27'h0, mask_r};
        `FPX_OFF_FLAGS:  rd_nxt = {29'h0, third_stage_exception_flag_r,
                                   primary_exception_flag_r, post_instruction_flag_r};
        `FPX_OFF_CMD:    rd_nxt = {third_stage_command_word_r, primary_command_word_r};
        `FPX_OFF_TAGS:   rd_nxt = {26'h0, destination_tag_r, source_tag_r};
        `FPX_OFF_SRC_HI: rd_nxt = {16'h0, source_temp_r.sign, source_temp_r.exponent};
        `FPX_OFF_SRC_MH: rd_nxt = source_temp_r.mantissa[63:32];
        `FPX_OFF_SRC_LO: rd_nxt = source_temp_r.mantissa[31:0];
        `FPX_OFF_DST_HI: rd_nxt = {16'h0, destination_temp_r.sign, destination_temp_r.exponent};
        `FPX_OFF_DST_MH: rd_nxt = destination_temp_r.mantissa[63:32];
        `FPX_OFF_DST_LO: rd_nxt = destination_temp_r.mantissa[31:0];
        `FPX_OFF_WB_HI:  rd_nxt = {writeback_temp_r.sign, writeback_temp_r.sticky,
                                   writeback_temp_r.mantissa[66:64], 11'h0,
                                   writeback_temp_r.exponent};
        `FPX_OFF_WB_MH:  rd_nxt = writeback_temp_r.mantissa[63:32];
        `FPX_OFF_WB_LO:  rd_nxt = writeback_temp_r.mantissa[31:0];
        default:         err_nxt = 1'b1;
    endcase
end

always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
        prdata_o  <= 32'h0000_0000;
        pslverr_o <= 1'b0;
        pready_o  <= 1'b0;
    end else begin
        if (apb_rd) begin
            prdata_o <= rd_nxt;
        end
        pslverr_o <= psel_i && !penable_i && err_nxt;
        pready_o  <= psel_i && !penable_i;
    end
end

endmodule // fpx_frame
`default_nettype wire

// >>> design/fpx_frame_pkg.sv
`default_nettype none
package fpx_frame_pkg;
    // Extended precision operand: sign, 15-bit exponent, 64-bit mantissa.
    typedef struct packed {
        logic        sign;
        logic [14:0] exponent;
        logic [63:0] mantissa;
    } fpx_ext_type;

    // Writeback intermediate image: 16-bit exponent, 67-bit mantissa, sticky.
    typedef struct packed {
        logic        sign;
        logic [15:0] exponent;
        logic [66:0] mantissa;
        logic        sticky;
    } fpx_wb_type;

    // Exception class, binary-encoded request from the arithmetic pipe.
    typedef enum logic [2:0] {
        FPX_EXC_NONE = 3'b000,
        FPX_EXC_SIG_NAN = 3'b001,
        FPX_EXC_OPER    = 3'b010,
        FPX_EXC_OVER    = 3'b011,
        FPX_EXC_UNDER   = 3'b100,
        FPX_EXC_DIV0    = 3'b101
    } fpx_exc_type;

    // Instruction group of the excepting instruction.
    typedef enum logic [1:0] {
        FPX_GRP_MOVE_REG = 2'b00,
        FPX_GRP_DYADIC   = 2'b01,
        FPX_GRP_MOVE_MEM = 2'b10,
        FPX_GRP_OTHER    = 2'b11
    } fpx_grp_type;

    // Exception report from the pipe, valid for one cycle.
    typedef struct packed {
        fpx_exc_type exc;
        fpx_grp_type grp;
        logic [15:0] cmd_word;
        logic [15:0] enc_cmd_word;
        fpx_ext_type src;
        logic [2:0]  src_tag;
        fpx_ext_type dst;
        logic [2:0]  dst_tag;
        logic        dst_valid;
        fpx_ext_type res_rounded;
        fpx_ext_type res_unrounded;
        fpx_wb_type  wb_image;
        logic [63:0] rounded_int;
    } fpx_report_type;
endpackage
`default_nettype wire

// >>> design/fpx_frame_regs.svh
`ifndef FPX_FRAME_REGS_SVH
`define FPX_FRAME_REGS_SVH
// Register byte offsets on the APB bus.
`define FPX_OFF_STATUS      12'h000
`define FPX_OFF_MASK        12'h004
`define FPX_OFF_FLAGS       12'h008
`define FPX_OFF_CMD         12'h00C
`define FPX_OFF_TAGS        12'h010
`define FPX_OFF_SRC_HI      12'h014
`define FPX_OFF_SRC_MH      12'h018
`define FPX_OFF_SRC_LO      12'h01C
`define FPX_OFF_DST_HI      12'h020
`define FPX_OFF_DST_MH      12'h024
`define FPX_OFF_DST_LO      12'h028
`define FPX_OFF_WB_HI       12'h02C
`define FPX_OFF_WB_MH       12'h030
`define FPX_OFF_WB_LO       12'h034
// Tag encodings.
`define FPX_TAG_NORM        3'h0
`define FPX_TAG_ZERO        3'h1
`define FPX_TAG_INF         3'h2
`define FPX_TAG_NAN         3'h3
`define FPX_TAG_XDEN        3'h4
`define FPX_TAG_SDEN        3'h5
// Opclass codes in command word bits 15..13.
`define FPX_OPC_REG         3'h0
`define FPX_OPC_MEM         3'h2
`define FPX_OPC_OUT         3'h3
`define FPX_OPC_MSB         15
`define FPX_OPC_LSB         13
// Signalling bit of a NaN mantissa (quiet bit position).
`define FPX_SIG_BIT         62
// Exponent marker bit in the writeback exponent.
`define FPX_WB_EXP_MSB      15
// Number of interrupt status bits.
`define FPX_NUM_EVT         5
`endif

// >>> sim/fpx_frame_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks; flag reads are judged against the newest accepted report.
module fpx_frame_monitor
    import fpx_frame_pkg::*;
(
    input wire logic           sys_clk_i,
    input wire logic           reset_n_i,
    input wire logic           exc_valid_i,
    input wire fpx_report_type exc_report_i,
    input wire logic           psel_i,
    input wire logic           penable_i,
    input wire logic           pwrite_i,
    input wire logic [11:0]    paddr_i,
    input wire logic [31:0]    pwdata_i,
    input wire logic [3:0]     pstrb_i,
    input wire logic [31:0]    prdata_o,
    input wire logic           pready_o,
    input wire logic           pslverr_o,
    input wire logic           irq_o
);
    fpx_exc_type last_exc_r;
    logic        last_out_r;
    logic        last_third_r;
    logic        rd_flags;
    logic        wr_mask;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////////////////////////
    // Track the last report; reads only make sense against it.
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            last_exc_r <= FPX_EXC_NONE;
            last_out_r <= 1'b0;
            last_third_r <= 1'b0;
        end else if (exc_valid_i && exc_report_i.exc != FPX_EXC_NONE) begin
            last_exc_r <= exc_report_i.exc;
            last_out_r <= exc_report_i.cmd_word[15:13] == 3'h3;
            last_third_r <= exc_report_i.grp == FPX_GRP_DYADIC &&
                            (exc_report_i.exc == FPX_EXC_OVER || exc_report_i.exc == FPX_EXC_UNDER);
        end
    end
    // Answer phases of interest.
    assign rd_flags = pready_o && !pwrite_i && paddr_i == 12'h008 && last_exc_r != FPX_EXC_NONE;
    assign wr_mask  = psel_i && penable_i && pwrite_i && paddr_i == 12'h004;
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    ////////////////////////////////////////////////////////////
    a_ready_access: assert property (s_setup ##1 psel_i && penable_i |-> pready_o)
        else $error("no pready in access cycle");
    a_ready_only: assert property (pready_o |-> psel_i && penable_i)
        else $error("pready outside access");
    a_ready_once: assert property (pready_o |=> !pready_o)
        else $error("pready held too long");
    a_err_unmapped: assert property (pready_o && paddr_i > 12'h034 |-> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (pready_o && paddr_i <= 12'h034 |-> !pslverr_o)
        else $error("mapped access refused");
    a_irq_cause: assert property ($rose(irq_o) |-> $past(exc_valid_i) || $past(exc_valid_i, 2)
                                  || $past(wr_mask) || $past(wr_mask, 2))
        else $error("irq rose without cause");
    a_third_flag: assert property (rd_flags && last_third_r |-> prdata_o[2])
        else $error("third-stage flag clear");
    a_primary_flag: assert property (rd_flags && !last_third_r |-> prdata_o[2:1] == 2'b01)
        else $error("primary flag wrong");
    a_post_flag: assert property (rd_flags && !last_third_r |-> prdata_o[0] == last_out_r)
        else $error("post flag wrong");
    a_wb_marker: assert property (pready_o && !pwrite_i && paddr_i == 12'h02C && last_third_r
                                  |-> prdata_o[15] == (last_exc_r == FPX_EXC_UNDER))
        else $error("writeback exponent marker wrong");
endmodule // fpx_frame_monitor
bind fpx_frame fpx_frame_monitor fpx_frame_monitor_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .exc_valid_i(exc_valid_i), .exc_report_i(exc_report_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o));
`default_nettype wire

// >>> sim/fpx_frame_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: a word model of the frame is read back after every report.
module fpx_frame_tb
    import fpx_frame_pkg::*;
;
    logic           sys_clk_i    = 1'b0;
    logic           reset_n_i    = 1'b0;
    logic           exc_valid_i  = 1'b0;
    fpx_report_type exc_report_i = '0;
    logic           psel_i       = 1'b0;
    logic           penable_i    = 1'b0;
    logic           pwrite_i     = 1'b0;
    logic [11:0]    paddr_i      = 12'h000;
    logic [31:0]    pwdata_i     = 32'h0;
    logic [3:0]     pstrb_i      = 4'h0;
    logic [31:0]    prdata_o;
    logic           pready_o;
    logic           pslverr_o;
    logic           irq_o;
    int             n_fail       = 0;
    int             check_count  = 0;
    int             cycles       = 0;
    logic [31:0]    seed         = 32'h0000176D;
    logic [31:0]    ev [16];
    logic [31:0]    ek [16];
    logic [31:0]    rd;
    logic           er;
    fpx_exc_type    xs [10] = '{FPX_EXC_SIG_NAN, FPX_EXC_OPER, FPX_EXC_OPER, FPX_EXC_OVER, FPX_EXC_OVER,
                                FPX_EXC_OVER, FPX_EXC_UNDER, FPX_EXC_UNDER, FPX_EXC_UNDER, FPX_EXC_DIV0};
    fpx_grp_type    gs [10] = '{FPX_GRP_OTHER, FPX_GRP_OTHER, FPX_GRP_OTHER, FPX_GRP_MOVE_REG,
                                FPX_GRP_DYADIC, FPX_GRP_MOVE_MEM, FPX_GRP_MOVE_REG, FPX_GRP_DYADIC,
                                FPX_GRP_MOVE_MEM, FPX_GRP_OTHER};
    logic [2:0]     os [10] = '{3'h3, 3'h0, 3'h3, 3'h2, 3'h0, 3'h3, 3'h0, 3'h2, 3'h3, 3'h2};
    fpx_frame fpx_frame_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .exc_valid_i(exc_valid_i),
        .exc_report_i(exc_report_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o));
    ////////////////////////////////////////////////////////////
    // Clock and a hang guard well above the expected run length.
    always #2.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic fpx_ext_type rext();
        logic [95:0] v;
        v = {rnd(), rnd(), rnd()};
        return v[79:0];
    endfunction
    // Model words keep a known-bit mask, so fields left free by a case are not judged.
    task automatic setw(int i, logic [31:0] v, logic [31:0] m);
        ev[i] = (ev[i] & ~m) | (v & m);
        ek[i] = ek[i] | m;
    endtask
    task automatic put_ext(int i, fpx_ext_type e);
        setw(i, {16'h0000, e.sign, e.exponent}, 32'h0000FFFF);
        setw(i + 1, e.mantissa[63:32], 32'hFFFFFFFF);
        setw(i + 2, e.mantissa[31:0], 32'hFFFFFFFF);
    endtask
    task automatic cmp32(logic [31:0] got, logic [31:0] exp, logic [31:0] m);
        check_count++;
        if ((got & m) !== (exp & m)) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got & m, exp & m);
        end
    endtask
    task automatic cmp1(logic got, logic exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request is held until pready is seen.
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd);
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        pstrb_i <= wr ? 4'(rnd()) : 4'h0;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do @(posedge sys_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic check_all();
        for (int i = 0; i < 16; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            cmp32(rd, ev[i], ek[i]);
            cmp1(er, i > 13);
        end
    endtask
    // Issue one report and move the model as the frame should move.
    task automatic send(fpx_exc_type x, fpx_grp_type g, logic [2:0] opc);
        fpx_report_type r;
        fpx_ext_type    e;
        fpx_wb_type     w;
        logic           out;
        logic           third;
        r = '0;
        r.exc = x;
        r.grp = g;
        r.cmd_word = {opc, 13'(rnd())};
        r.enc_cmd_word = 16'(rnd());
        r.src = rext();
        r.dst = rext();
        r.res_rounded = rext();
        r.res_unrounded = rext();
        r.src_tag = 3'(rnd() % 6);
        r.dst_tag = 3'(rnd() % 6);
        r.dst_valid = 1'b1;
        r.wb_image = {rext(), 5'(rnd())};
        r.rounded_int = {rnd(), rnd()};
        @(posedge sys_clk_i);
        exc_valid_i <= 1'b1;
        exc_report_i <= r;
        @(posedge sys_clk_i);
        exc_valid_i <= 1'b0;
        out = opc == 3'h3;
        third = g == FPX_GRP_DYADIC && (x == FPX_EXC_OVER || x == FPX_EXC_UNDER);
        ev[0] = ev[0] | (32'h1 << (int'(x) - 1));
        if (!(x == FPX_EXC_DIV0 || third)) setw(3, {16'h0000, r.cmd_word}, 32'h0000FFFF);
        setw(2, third ? 32'h4 : {30'h0, 1'b1, out}, 32'h7);
        if (third) ek[2][1:0] = 2'h0;
        case (x)
            FPX_EXC_SIG_NAN: begin
                e = r.src;
                e.mantissa[62] = 1'b1;
                put_ext(5, e);
                setw(4, 32'h3, 32'h7);
            end
            FPX_EXC_OPER: begin
                put_ext(5, r.src);
                setw(4, {26'h0, r.dst_tag, r.src_tag}, out ? 32'h7 : 32'h3F);
                if (out) begin
                    setw(11, 32'h0, 32'h38000000);
                    setw(12, r.rounded_int[63:32], 32'hFFFFFFFF);
                    setw(13, r.rounded_int[31:0], 32'hFFFFFFFF);
                end else put_ext(8, r.dst);
            end
            FPX_EXC_DIV0: begin
                put_ext(5, r.src);
                put_ext(8, r.dst);
                setw(4, {29'h0, r.src_tag}, 32'h7);
                ek[3][15:0] = 16'h0000;
                ek[4][5:3] = 3'h0;
            end
            default: if (third) begin
                setw(3, {r.enc_cmd_word, 16'h0000}, 32'hFFFF0000);
                e = r.res_rounded;
                w = r.wb_image;
                if (x == FPX_EXC_OVER) begin
                    setw(11, {e.sign, 2'h0, e.mantissa[63:62], 11'h0, 1'b0, e.exponent}, 32'h9800FFFF);
                    setw(12, e.mantissa[61:30], 32'hFFFFFFFF);
                    setw(13, {e.mantissa[29:0], 2'h0}, 32'hFFFFFFFC);
                end else begin
                    setw(11, {w.sign, w.sticky, w.mantissa[66:64], 11'h0, 1'b1, w.exponent[14:0]}, 32'hF800FFFF);
                    setw(12, w.mantissa[63:32], 32'hFFFFFFFF);
                    setw(13, w.mantissa[31:0], 32'hFFFFFFFF);
                end
            end else begin
                put_ext(8, x == FPX_EXC_OVER ? r.res_rounded : r.res_unrounded);
                setw(4, 32'h0, 32'h7);
            end
        endcase
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Reset values first, then ten report cases twice with random operands and masks.
    initial begin
        logic [31:0] c;
        for (int i = 0; i < 16; i++) begin
            ev[i] = 32'h0;
            ek[i] = 32'hFFFFFFFF;
        end
        repeat (8) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        check_all();
        $display("reset test done");
        for (int n = 0; n < 20; n++) begin
            c = rnd() & 32'h1F;
            apb(1'b1, 12'h004, c);
            if (pstrb_i[0]) setw(1, c, 32'h1F);
            apb(1'b1, 12'h008, rnd());
            send(xs[n % 10], gs[n % 10], os[n % 10]);
            repeat (2) @(posedge sys_clk_i);
            cmp1(irq_o, (ev[0] & ev[1]) != 0);
            check_all();
            c = rnd() & 32'h1F;
            apb(1'b1, 12'h000, c);
            if (pstrb_i[0]) ev[0] = ev[0] & ~c;
            repeat (2) @(posedge sys_clk_i);
            cmp1(irq_o, (ev[0] & ev[1]) != 0);
            $display("case %0d done", n);
        end
        wrap_up();
    end
endmodule // fpx_frame_tb
`default_nettype wire
